// [sle_params.svh]
`ifndef SLE_PARAMS_SVH
`define SLE_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SLE_OFS_CTRL      8'h00
`define SLE_OFS_STATUS    8'h04
`define SLE_OFS_IRQ_STAT  8'h08
`define SLE_OFS_IRQ_EN    8'h0C
`define SLE_OFS_IRQ_CLR   8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define SLE_CTRL_UPD_BIT  6
`define SLE_CTRL_W        6
`define SLE_STAT_ST_LSB   16
`define SLE_STAT_PEND_BIT 18
`define SLE_IRQ_W         4
`define SLE_IRQ_START     0
`define SLE_IRQ_ERR       1
`define SLE_IRQ_CHFLT     2
`define SLE_IRQ_LINK      3

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define SLE_CTRL_RST      6'h00
`define SLE_IRQ_EN_RST    4'h0
`define SLE_RESP_OKAY     2'h0
`define SLE_RESP_DECERR   2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define SLE_CLK_HZ        100000000
`define SLE_START_S       5
`define SLE_UPD_S         30
`define SLE_FLASH_FAST_HZ 2

`endif

// [sle_pkg.sv]
package sle_pkg;

	// ****************************************************************
	// Unit states, Gray coded along start, run, update
	// ****************************************************************
	typedef enum logic [1:0] {
		SLE_ST_START = 2'b00,
		SLE_ST_RUN   = 2'b01,
		SLE_ST_UPD   = 2'b11,
		SLE_ST_ERR   = 2'b10
	} sle_state_t;

	// Lamp drive, one bit per lamp, high lights it
	typedef struct packed {
		logic       supply_indicator;
		logic       operation_indicator;
		logic       error_maintenance_indicator;
		logic       link_indicator_b;
		logic       link_indicator_a;
		logic [7:0] channel_indicator;
	} sle_lamp_t;

	// Asynchronous field conditions
	typedef struct packed {
		logic [1:0] link_up;
		logic [7:0] ch_sig;
		logic [7:0] ch_flt;
		logic       overtemp;
		logic       no_load_v;
	} sle_pins_t;

	// Software held unit conditions
	typedef struct packed {
		logic identify;
		logic param_err;
		logic cfg_mismatch;
		logic maint_req;
		logic int_err;
		logic connected;
	} sle_ctrl_t;

endpackage : sle_pkg

// [sle_sync.sv]
`timescale 1ns/1ps

// ****************************************************************
// Two stage synchroniser for asynchronous levels
// ****************************************************************
module sle_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk,     // System clock
	input  wire logic         i_sys_rst, // Synchronous reset
	input  wire logic [W-1:0] i_async,   // Level from outside
	output logic      [W-1:0] o_sync     // Level in clock domain
);

	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule : sle_sync

// [sle_flash_gen.sv]
`timescale 1ns/1ps

// ****************************************************************
// Flash divider: fast and slow square waves
// ****************************************************************
module sle_flash_gen #(
	parameter logic [31:0] P_HALF = 32'h017D7840
) (
	input  wire logic i_clk,       // System clock
	input  wire logic i_sys_rst,   // Synchronous reset
	output logic      o_flash_2hz, // Fast flash wave
	output logic      o_flash_1hz  // Slow flash wave
);

	logic [31:0] cnt_r;

	// Half period counter
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || cnt_r >= P_HALF - 32'h1) begin
			cnt_r <= 32'h0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end

	// Slow wave toggles on each falling fast edge, so both stay in phase
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_flash_2hz <= 1'b0;
			o_flash_1hz <= 1'b0;
		end else if (cnt_r >= P_HALF - 32'h1) begin
			o_flash_2hz <= ~o_flash_2hz;
			if (o_flash_2hz) begin
				o_flash_1hz <= ~o_flash_1hz;
			end
		end
	end

endmodule : sle_flash_gen

// [sle_top.sv]
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sle_params.svh"

module sle_top
	import sle_pkg::*;
#(
	parameter logic [31:0] P_START_CYC = 32'(64'(`SLE_START_S) * 64'(`SLE_CLK_HZ)),
	parameter logic [31:0] P_UPD_CYC   = 32'(64'(`SLE_UPD_S) * 64'(`SLE_CLK_HZ)),
	parameter logic [31:0] P_HALF_FAST = 32'(`SLE_CLK_HZ / (2 * `SLE_FLASH_FAST_HZ))
) (
	input  wire logic        i_clk,             // System clock, 100 MHz
	input  wire logic        i_sys_rst,         // Synchronous reset, high
	input  wire sle_pins_t   i_pins,            // Field conditions, asynchronous
	input  wire logic [7:0]  i_s_axi_awaddr,    // Write address
	input  wire logic        i_s_axi_awvalid,   // Write address valid
	output logic             o_s_axi_awready,   // Write address ready
	input  wire logic [31:0] i_s_axi_wdata,     // Write data
	input  wire logic [3:0]  i_s_axi_wstrb,     // Write byte enables
	input  wire logic        i_s_axi_wvalid,    // Write data valid
	output logic             o_s_axi_wready,    // Write data ready
	output logic [1:0]       o_s_axi_bresp,     // Write response
	output logic             o_s_axi_bvalid,    // Write response valid
	input  wire logic        i_s_axi_bready,    // Write response ready
	input  wire logic [7:0]  i_s_axi_araddr,    // Read address
	input  wire logic        i_s_axi_arvalid,   // Read address valid
	output logic             o_s_axi_arready,   // Read address ready
	output logic [31:0]      o_s_axi_rdata,     // Read data
	output logic [1:0]       o_s_axi_rresp,     // Read response
	output logic             o_s_axi_rvalid,    // Read data valid
	input  wire logic        i_s_axi_rready,    // Read data ready
	output sle_lamp_t        o_lamp,            // Lamp drive
	output logic             o_irq              // Interrupt level
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic logic sle_is_mapped(input logic [7:0] addr);
		logic [7:0] a;
		a = {addr[7:2], 2'b00};
		sle_is_mapped = (a == `SLE_OFS_CTRL) || (a == `SLE_OFS_STATUS) ||
			(a == `SLE_OFS_IRQ_STAT) || (a == `SLE_OFS_IRQ_EN) ||
			(a == `SLE_OFS_IRQ_CLR);
	endfunction : sle_is_mapped

	sle_pins_t                  pins_s;
	sle_ctrl_t                  ctrl_r;
	sle_state_t                 st_r;
	sle_state_t                 st_nxt;
	sle_lamp_t                  lamp_nxt;
	logic [31:0]                tmr_r;
	logic                       upd_req_r;
	logic                       f2;
	logic                       f1;
	logic [`SLE_IRQ_W-1:0]      irq_stat_r;
	logic [`SLE_IRQ_W-1:0]      irq_en_r;
	logic [`SLE_IRQ_W-1:0]      irq_ev;
	logic [`SLE_IRQ_W-1:0]      irq_clr;
	logic [7:0]                 flt_d_r;
	logic [1:0]                 link_d_r;
	logic [7:0]                 ch_lamp;
	logic                       flash_flt;
	logic                       steady_flt;
	logic                       aw_hold_r;
	logic                       w_hold_r;
	logic [7:0]                 awaddr_r;
	logic [31:0]                wdata_r;
	logic [3:0]                 wstrb_r;
	logic                       wr_go;
	logic [7:0]                 wa;
	logic                       wr_lo;

	// ****************************************************************
	// Input conditioning and flash sources
	// ****************************************************************
	sle_sync #(
		.W ($bits(sle_pins_t))
	) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_pins),
		.o_sync    (pins_s)
	);

	sle_flash_gen #(
		.P_HALF (P_HALF_FAST)
	) u_flash (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.o_flash_2hz (f2),
		.o_flash_1hz (f1)
	);

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	assign o_s_axi_awready = !aw_hold_r && !o_s_axi_bvalid;
	assign o_s_axi_wready  = !w_hold_r && !o_s_axi_bvalid;
	assign wr_go = aw_hold_r && w_hold_r && !o_s_axi_bvalid;
	assign wa    = {awaddr_r[7:2], 2'b00};
	assign wr_lo = wr_go && wstrb_r[0];

	// Address and data are caught independently, in either order
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
		end else begin
			if (o_s_axi_awready && i_s_axi_awvalid) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= i_s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_r <= 1'b0;
			end
			if (o_s_axi_wready && i_s_axi_wvalid) begin
				w_hold_r <= 1'b1;
				wdata_r  <= i_s_axi_wdata;
				wstrb_r  <= i_s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_r <= 1'b0;
			end
		end
	end

	// Response stands until the master takes it
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= `SLE_RESP_OKAY;
		end else if (wr_go) begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp  <= sle_is_mapped(awaddr_r) ? `SLE_RESP_OKAY : `SLE_RESP_DECERR;
		end else if (i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	// All fields live in byte lane 0, so only that strobe matters
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl_r   <= `SLE_CTRL_RST;
			irq_en_r <= `SLE_IRQ_EN_RST;
		end else if (wr_lo) begin
			if (wa == `SLE_OFS_CTRL) begin
				ctrl_r <= wdata_r[`SLE_CTRL_W-1:0];
			end
			if (wa == `SLE_OFS_IRQ_EN) begin
				irq_en_r <= wdata_r[`SLE_IRQ_W-1:0];
			end
		end
	end

	// Update request is a one-shot; held until the unit enters update
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			upd_req_r <= 1'b0;
		end else if (wr_lo && wa == `SLE_OFS_CTRL && wdata_r[`SLE_CTRL_UPD_BIT]) begin
			upd_req_r <= 1'b1;
		end else if (st_nxt == SLE_ST_UPD) begin
			upd_req_r <= 1'b0;
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	assign o_s_axi_arready = !o_s_axi_rvalid;

	// Data stands until the master takes it
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= 32'h0;
			o_s_axi_rresp  <= `SLE_RESP_OKAY;
		end else if (o_s_axi_arready && i_s_axi_arvalid) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp  <= sle_is_mapped(i_s_axi_araddr) ? `SLE_RESP_OKAY : `SLE_RESP_DECERR;
			case ({i_s_axi_araddr[7:2], 2'b00})
				`SLE_OFS_CTRL:     o_s_axi_rdata <= {26'h0, ctrl_r};
				`SLE_OFS_STATUS:   o_s_axi_rdata <= {13'h0, upd_req_r, st_r, 3'h0, o_lamp};
				`SLE_OFS_IRQ_STAT: o_s_axi_rdata <= {28'h0, irq_stat_r};
				`SLE_OFS_IRQ_EN:   o_s_axi_rdata <= {28'h0, irq_en_r};
				default:           o_s_axi_rdata <= 32'h0;
			endcase
		end else if (i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Unit state machine
	// ****************************************************************
	// Internal error overrides every other state
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			SLE_ST_START: begin
				if (ctrl_r.int_err) begin
					st_nxt = SLE_ST_ERR;
				end else if (tmr_r >= P_START_CYC - 32'h1) begin
					st_nxt = SLE_ST_RUN;
				end
			end
			SLE_ST_RUN: begin
				if (ctrl_r.int_err) begin
					st_nxt = SLE_ST_ERR;
				end else if (upd_req_r) begin
					st_nxt = SLE_ST_UPD;
				end
			end
			SLE_ST_UPD: begin
				if (ctrl_r.int_err) begin
					st_nxt = SLE_ST_ERR;
				end else if (tmr_r >= P_UPD_CYC - 32'h1) begin
					st_nxt = SLE_ST_START;
				end
			end
			SLE_ST_ERR: begin
				if (!ctrl_r.int_err) begin
					st_nxt = SLE_ST_START;
				end
			end
			default: begin
				st_nxt = SLE_ST_START;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r <= SLE_ST_START;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Dwell timer restarts on each state change
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || st_nxt != st_r) begin
			tmr_r <= 32'h0;
		end else if (tmr_r != 32'hFFFFFFFF) begin
			tmr_r <= tmr_r + 32'h1;
		end
	end

	// ****************************************************************
	// Lamp encoding
	// ****************************************************************
	assign flash_flt  = (|pins_s.ch_flt) || pins_s.overtemp || pins_s.no_load_v;
	assign steady_flt = ctrl_r.cfg_mismatch || ctrl_r.param_err || ctrl_r.maint_req;

	// Per channel: fault flashes, otherwise the signal shows
	for (genvar g = 0; g < 8; g++) begin : g_chan
		assign ch_lamp[g] = pins_s.ch_flt[g] ? f2 : pins_s.ch_sig[g];
	end

	always_comb begin
		lamp_nxt                  = '0;
		lamp_nxt.link_indicator_a = pins_s.link_up[0];
		lamp_nxt.link_indicator_b = pins_s.link_up[1];
		lamp_nxt.channel_indicator = ch_lamp;
		lamp_nxt.supply_indicator = 1'b1;
		case (st_r)
			SLE_ST_ERR: begin
				lamp_nxt.operation_indicator         = f2;
				lamp_nxt.error_maintenance_indicator = f2;
				lamp_nxt.channel_indicator           = {8{f2}};
			end
			SLE_ST_START: begin
				lamp_nxt.operation_indicator         = 1'b1;
				lamp_nxt.error_maintenance_indicator = 1'b1;
			end
			SLE_ST_UPD: begin
				lamp_nxt.operation_indicator = f1;
			end
			SLE_ST_RUN: begin
				if (ctrl_r.identify) begin
					lamp_nxt.supply_indicator            = f1;
					lamp_nxt.operation_indicator         = f1;
					lamp_nxt.error_maintenance_indicator = f1;
				end else begin
					lamp_nxt.operation_indicator = ctrl_r.connected ? 1'b1 : f1;
					if (flash_flt) begin
						lamp_nxt.error_maintenance_indicator = f2;
					end else begin
						lamp_nxt.error_maintenance_indicator = steady_flt;
					end
				end
			end
			default: begin
				lamp_nxt.operation_indicator = 1'b0;
			end
		endcase
	end

	// Lamps come from flip-flops so no glitches reach the pins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_lamp <= '0;
		end else begin
			o_lamp <= lamp_nxt;
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	assign irq_ev[`SLE_IRQ_START] = (st_r == SLE_ST_START) && (st_nxt == SLE_ST_RUN);
	assign irq_ev[`SLE_IRQ_ERR]   = (st_r != SLE_ST_ERR) && (st_nxt == SLE_ST_ERR);
	assign irq_ev[`SLE_IRQ_CHFLT] = |(pins_s.ch_flt & ~flt_d_r);
	assign irq_ev[`SLE_IRQ_LINK]  = |(pins_s.link_up ^ link_d_r);
	assign irq_clr = (wr_lo && wa == `SLE_OFS_IRQ_CLR) ? wdata_r[`SLE_IRQ_W-1:0] : '0;
	assign o_irq   = |(irq_stat_r & irq_en_r);

	// A new event in the clearing cycle wins over the clear
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			irq_stat_r <= '0;
			flt_d_r    <= 8'h00;
			link_d_r   <= 2'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			flt_d_r    <= pins_s.ch_flt;
			link_d_r   <= pins_s.link_up;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_upd_end;
		st_r == SLE_ST_UPD && tmr_r == P_UPD_CYC - 32'h1 && !ctrl_r.int_err;
	endsequence

	sequence s_restart;
		st_r == SLE_ST_START ##1 o_lamp.error_maintenance_indicator;
	endsequence

	run_good_a: assert property ((st_r == SLE_ST_RUN && ctrl_r.connected && !ctrl_r.identify &&
		!flash_flt && !steady_flt) |=> (o_lamp.supply_indicator && o_lamp.operation_indicator &&
		!o_lamp.error_maintenance_indicator)) else $error("good state lamps wrong");
	start_len_a: assert property (st_r == SLE_ST_START |-> tmr_r < P_START_CYC)
		else $error("startup too long");
	start_lamps_a: assert property ((st_r == SLE_ST_START && !ctrl_r.int_err) |=>
		(o_lamp.supply_indicator && o_lamp.operation_indicator &&
		o_lamp.error_maintenance_indicator)) else $error("startup lamps wrong");
	err_flash_a: assert property (st_r == SLE_ST_ERR |=>
		(o_lamp.operation_indicator == $past(f2) && o_lamp.error_maintenance_indicator == $past(f2)
		&& o_lamp.channel_indicator == {8{$past(f2)}})) else $error("error flash wrong");
	upd_restart_a: assert property (s_upd_end |=> s_restart)
		else $error("no restart after update");
	upd_lamps_a: assert property (st_r == SLE_ST_UPD |=>
		(o_lamp.supply_indicator && o_lamp.operation_indicator == $past(f1)))
		else $error("update lamps wrong");
	no_conn_a: assert property ((st_r == SLE_ST_RUN && !ctrl_r.connected && !ctrl_r.identify) |=>
		(o_lamp.supply_indicator && o_lamp.operation_indicator == $past(f1)))
		else $error("unconnected lamps wrong");
	maint_on_a: assert property ((st_r == SLE_ST_RUN && !ctrl_r.identify && !flash_flt &&
		(ctrl_r.maint_req || ctrl_r.cfg_mismatch || ctrl_r.param_err)) |=>
		o_lamp.error_maintenance_indicator) else $error("group fault dark");
	link_follow_a: assert property (##1 {o_lamp.link_indicator_b, o_lamp.link_indicator_a} ==
		$past(pins_s.link_up)) else $error("link lamp mismatch");
	chan_show_a: assert property (st_r != SLE_ST_ERR |=> o_lamp.channel_indicator ==
		(($past(pins_s.ch_sig) & ~$past(pins_s.ch_flt)) | ($past(pins_s.ch_flt) & {8{$past(f2)}})))
		else $error("channel lamp wrong");
	flt_flash_a: assert property ((st_r == SLE_ST_RUN && !ctrl_r.identify && flash_flt) |=>
		o_lamp.error_maintenance_indicator == $past(f2)) else $error("fault not flashing");
	err_prio_a: assert property ((ctrl_r.int_err && st_r != SLE_ST_ERR) |=> st_r == SLE_ST_ERR)
		else $error("internal error not first");

endmodule : sle_top

// [sle_lamp_obs.sv]
`timescale 1ns/1ps

// ****************************************************************
// Lamp observer: counts the changes of each lamp over a window
// ****************************************************************
module sle_lamp_obs
	import sle_pkg::*;
(
	input  wire logic        i_clk,  // System clock
	input  wire logic        i_clr,  // Restart the window
	input  wire sle_lamp_t   i_lamp, // Lamps as seen
	output logic [12:0][5:0] o_tog   // Changes per lamp
);
	logic [12:0] prev_r; // Level one cycle back

	// A viewer tells steady from flashing only over a span, so count changes
	always_ff @(posedge i_clk) begin
		prev_r <= i_lamp;
		for (int i = 0; i < 13; i++) begin
			if (i_clr)
				o_tog[i] <= 6'h00;
			else if (prev_r[i] != i_lamp[i])
				o_tog[i] <= o_tog[i] + 6'h01;
		end
	end
endmodule : sle_lamp_obs

// [status_led_indicator_encoder_tb.sv]
`timescale 1ns/1ps
`include "sle_params.svh"

module status_led_indicator_encoder_tb;
	import sle_pkg::*;
	localparam int N_START = 50;
	localparam int N_UPD   = 80;
	logic             clk, rst, clr, awvalid, wvalid, bready, arvalid, rready;
	logic             awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0]       awaddr, araddr;
	logic [31:0]      wdata, rdata, d;
	logic [3:0]       wstrb;
	logic [1:0]       bresp, rresp, r;
	sle_pins_t        pins, p;
	sle_lamp_t        lamp;
	logic [12:0][5:0] tog;
	logic [5:0]       c;
	logic             sup;
	int               n_mismatch, tests_run, seed, cnt, tg;

	// ****************************************************************
	// Design, observer, clock
	// ****************************************************************
	sle_top #(.P_START_CYC(32'h32), .P_UPD_CYC(32'h50), .P_HALF_FAST(32'h4)) u_dut (
		.i_clk(clk), .i_sys_rst(rst), .i_pins(pins),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_lamp(lamp), .o_irq(irq));
	sle_lamp_obs u_obs (.i_clk(clk), .i_clr(clr), .i_lamp(lamp), .o_tog(tog));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Handshakes are judged at the negedge, where comb readies are settled
	task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rs = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = arvalid & arready;
			tr = rvalid;
			dv = rdata;
			rs = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
	endtask : rd

	// Lamp kind per two bits: 0 dark, 1 lit, 2 slow flash, 3 fast flash
	function automatic logic [25:0] exp_lamps(input logic [5:0] cv, input sle_pins_t pv);
		logic [25:0] e;
		e[25:24] = 2'h1;
		e[23:22] = cv[1] ? 2'h3 : (cv[0] ? 2'h1 : 2'h2);
		e[21:20] = (cv[1] | (|pv.ch_flt) | pv.overtemp | pv.no_load_v) ? 2'h3 :
			((|cv[4:2]) ? 2'h1 : 2'h0);
		e[19:18] = {1'b0, pv.link_up[1]};
		e[17:16] = {1'b0, pv.link_up[0]};
		for (int i = 0; i < 8; i++)
			e[2*i+:2] = (cv[1] | pv.ch_flt[i]) ? 2'h3 : {1'b0, pv.ch_sig[i]};
		if (cv[5] && !cv[1]) e[25:20] = 6'h2A; // Identify: three unit lamps slow
		return e;
	endfunction : exp_lamps

	task automatic run_case(input logic [5:0] cv, input sle_pins_t pv);
		logic [25:0] k;
		pins <= pv;
		wr(`SLE_OFS_CTRL, 32'(cv), r);
		// Long enough to ride out the restart that follows a cleared error
		repeat (N_START + 8) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (32) @(posedge clk);
		@(negedge clk);
		for (int i = 0; i < 13; i++)
			k[2*i+:2] = (tog[i] == 6'h00) ? {1'b0, lamp[i]} : ((tog[i] >= 6'h06) ? 2'h3 : 2'h2);
		chk("lamps", 32'(k), 32'(exp_lamps(cv, pv)));
	endtask : run_case

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	// Run takes under 3000 cycles; 20000 can only mean a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = 83936;
		{rst, clr, awvalid, wvalid, bready, arvalid, rready} = 7'h41;
		{awaddr, araddr, wdata, wstrb} = '0;
		wstrb = 4'hF;
		pins = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("start lamps", 32'(lamp[12:10]), 32'h7);
		cnt = 0;
		while (lamp.error_maintenance_indicator && cnt < 200) begin
			@(negedge clk);
			cnt++;
		end
		chk("start length", 32'(cnt >= N_START - 2 && cnt <= N_START + 2), 32'h1);
		rd(`SLE_OFS_STATUS, d, r);
		chk("state run", 32'(d[17:16]), 32'h1);
		$display("Done startup");
		rd(`SLE_OFS_IRQ_EN, d, r);
		chk("irq en reset", d, 32'h0);
		rd(`SLE_OFS_IRQ_STAT, d, r);
		chk("start event", d, 32'h1);
		chk("masked irq", 32'(irq), 32'h0);
		wr(`SLE_OFS_IRQ_EN, 32'h1, r);
		@(negedge clk);
		chk("irq on", 32'(irq), 32'h1);
		wr(`SLE_OFS_IRQ_CLR, 32'h1, r);
		@(negedge clk);
		chk("irq clear", 32'(irq), 32'h0);
		wr(`SLE_OFS_IRQ_EN, 32'h8, r);
		pins.link_up <= 2'h2;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("link irq", 32'(irq), 32'h1);
		rd(8'h14, d, r);
		chk("unmapped rd", {d[29:0], r}, 32'h3);
		wr(8'h40, 32'h1, r);
		chk("unmapped wr", 32'(r), 32'h3);
		$display("Done registers");
		for (int i = 0; i < 12; i++) begin
			p = 20'($random(seed));
			c = {1'b0, 4'(i < 4 ? (1 << i) : $random(seed)), 1'($random(seed))};
			if (i < 6) {p.ch_flt, p.overtemp, p.no_load_v} = '0;
			if (i == 6) {p.ch_flt, p.overtemp, p.no_load_v} = 10'h002;
			if (i == 7) {p.ch_flt, p.overtemp, p.no_load_v} = 10'h001;
			run_case(c, p);
		end
		run_case(6'h21, 20'($random(seed)));
		run_case(6'h03, 20'($random(seed)));
		$display("Done lamp cases");
		wr(`SLE_OFS_CTRL, 32'h1, r);
		rd(`SLE_OFS_STATUS, d, r);
		chk("error exit", 32'(d[17:16]), 32'h0);
		repeat (60) @(posedge clk);
		pins <= '0;
		wr(`SLE_OFS_CTRL, 32'h41, r);
		@(negedge clk);
		{cnt, tg, sup} = {32'h0, 32'h0, 1'b1};
		while (lamp[12:10] != 3'h7 && cnt < 200) begin
			@(negedge clk);
			sup = sup & lamp.supply_indicator;
			if (lamp.operation_indicator != u_obs.prev_r[11]) tg++;
			cnt++;
		end
		chk("update length", 32'(cnt >= N_UPD - 4 && cnt <= N_UPD + 2), 32'h1);
		chk("update slow", 32'(tg >= 6 && tg <= 12), 32'h1);
		chk("update supply", 32'(sup), 32'h1);
		$display("Done update");
		end_sim();
	end
endmodule : status_led_indicator_encoder_tb
